// *** host_model.sv ***
// Purpose: Remote host byte sender
// Assumes: One byte every two cycles, no backpressure
// Notes:   Idle data is the inverse of the last byte
`timescale 1ns/100ps
module host_model
(
  input  wire logic       clk,
  output logic      [7:0] rx_data = 8'h00,
  output logic            rx_valid = 1'b0,
  output logic            rx_eoi = 1'b0
);
  task send(input logic [7:0] b, input logic last);
    @(posedge clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    rx_eoi <= last;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_eoi <= 1'b0;
    rx_data <= ~b;
  endtask : send
endmodule : host_model

// *** seq_loader_pkg.sv ***
// Purpose: Shared constants and types for the sequence table loader
// Assumes: Two output channels, one table buffer each
// Notes:   Register offsets are byte addresses on a 32-bit bus
package seq_loader_pkg;
  // ==========================================================
  // Table geometry
  localparam int          CHAN_W      = 1;
  localparam int          CHANNELS    = 2;
  localparam int          INDEX_W     = 15;
  localparam int          ADDR_W      = CHAN_W + INDEX_W;
  localparam int          ENTRY_W     = 64;
  localparam logic [15:0] MIN_STEPS   = 16'h0003;
  localparam logic [15:0] MAX_STEPS   = 16'h8000;
  localparam logic [15:0] MIN_SEGMENT = 16'h0001;
  localparam logic [15:0] MAX_SEGMENT = 16'h7d00;
  localparam logic [31:0] MIN_LOOPS   = 32'h0000_0001;
  localparam logic [31:0] MAX_LOOPS   = 32'h000f_ffff;
  localparam logic [15:0] MAX_JUMP    = 16'h0001;
  // ==========================================================
  // Entry layout, byte 0 of an entry lands in bit 0
  localparam int          LOOPS_LSB   = 0;
  localparam int          SEG_LSB     = 32;
  localparam int          JUMP_LSB    = 48;
  localparam logic [2:0]  LAST_BYTE   = 3'h7;
  // ==========================================================
  // Block header characters
  localparam logic [7:0]  HASH_CHAR   = 8'h23;
  localparam logic [7:0]  DIGIT_ONE   = 8'h31;
  localparam logic [7:0]  DIGIT_ZERO  = 8'h30;
  localparam logic [7:0]  DIGIT_NINE  = 8'h39;
  // ==========================================================
  // Register map
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STEP    = 8'h04;
  localparam logic [7:0]  REG_SEGMENT = 8'h08;
  localparam logic [7:0]  REG_LOOPS   = 8'h0c;
  localparam logic [7:0]  REG_JUMP    = 8'h10;
  localparam logic [7:0]  REG_COMMAND = 8'h14;
  localparam logic [7:0]  REG_STATUS  = 8'h18;
  localparam logic [7:0]  REG_LENGTH  = 8'h1c;
  localparam logic [7:0]  REG_PLAY    = 8'h20;
  // CTRL fields
  localparam int          CTRL_SEQ    = 0;
  localparam int          CTRL_JSRC   = 1;
  localparam int          CTRL_CHAN   = 8;
  // COMMAND fields
  localparam int          CMD_DEFINE  = 0;
  localparam int          CMD_TRIGGER = 1;
  // STATUS fields
  localparam int          ST_DEF_ERR  = 0;
  localparam int          ST_DONE     = 1;
  localparam int          ST_RANGE    = 2;
  localparam int          ST_BUSY     = 3;

  typedef enum logic [3:0] {
    P_HUNT  = 4'b0001,
    P_NDIG  = 4'b0010,
    P_COUNT = 4'b0100,
    P_DATA  = 4'b1000
  } parse_state_t;

  typedef enum logic [4:0] {
    Q_IDLE  = 5'b00001,
    Q_FETCH = 5'b00010,
    Q_LOAD  = 5'b00100,
    Q_PLAY  = 5'b01000,
    Q_DWELL = 5'b10000
  } play_state_t;
endpackage : seq_loader_pkg

// *** seq_loader_props.sv ***
// Purpose: Port checks for the loader
// Assumes: Bench loads in-range tables only
// Notes:   Bound to each loader
`timescale 1ns/100ps
module seq_loader_props
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        hresp,
  input wire logic        hreadyout,
  input wire logic        event_in,
  input wire logic [15:0] play_segment,
  input wire logic [15:0] play_step,
  input wire logic        play_valid,
  input wire logic        dwell,
  input wire logic        restart
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ok_resp_a: assert property (hresp == 1'b0) else $error("bad hresp");
  ready_back_a: assert property (!hreadyout |-> ##[1:16] hreadyout) else $error("slave stuck");
  seg_range_a: assert property (play_valid |-> play_segment inside {[16'h0001:16'h7d00]}) else $error("seg");
  step_low_a: assert property (play_valid |-> play_step != 16'h0) else $error("step 0");
  step_high_a: assert property (play_valid |-> play_step <= 16'h8000) else $error("step max");
  dwell_play_a: assert property (dwell |-> play_valid) else $error("idle dwell");
  dwell_hold_a: assert property (dwell && !event_in && !$past(event_in) && !restart |=> dwell || restart) else $error("dw");
  restart_pulse_a: assert property (restart |-> ##[1:16] !restart) else $error("restart");
  cover property (dwell);
  cover property (restart);
  cover property (play_valid);
endmodule : seq_loader_props
bind sequence_table_loader seq_loader_props seq_loader_props_i
(
  .clk          (clk),
  .reset        (reset),
  .hresp        (hresp),
  .hreadyout    (hreadyout),
  .event_in     (event_in),
  .play_segment (play_segment),
  .play_step    (play_step),
  .play_valid   (play_valid),
  .dwell        (dwell),
  .restart      (restart)
);

// *** sequence_table_loader.sv ***
// Purpose: Loads per-channel step tables from a binary block or single step definitions
// Assumes: Byte stream and event input synchronous to clk; AHB-Lite register slave
// Notes:   Includes a small step player so the jump flag has meaning
// What this block does
// - A hash byte starts a definite-length binary block header.
// - Next digit tells how many count digits follow; decode the byte count.
// - Each entry is a 64-bit value built from eight arriving bytes.
// - Entry splits into 32-bit loops, 16-bit segment, 16-bit jump flag.
// - Any byte value is accepted as block payload.
// - CR and LF bytes inside data are stored, never end the block.
// - Each channel has its own table; loads go to the selected one.
// - Tables hold from 3 to 32,768 steps; definitions and blocks can set a shorter length, which is not played.
// - Binary contents are not validated during transfer.
// - Steps are numbered in arrival order starting at one.
// - Defining a step sets table length to the defined entry count.
// - Segment number must be 1 to 32,000; played when step reached.
// - Loop count 1 to 1,048,575 repeats the segment before advancing.
// - Jump flag 1 dwells on the step until an event; 0 advances.
// - Defining a step during sequenced output rebuilds and restarts it.
// - Releasing event comes from bus trigger or event input, as selected.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sequence_table_loader
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_eoi,
  input  wire logic        event_in,
  input  wire logic        segment_done,
  output logic      [15:0] play_segment,
  output logic      [15:0] play_step,
  output logic             play_valid,
  output logic             dwell,
  output logic             restart
);
  // ==========================================================
  // Block state
  typedef struct packed {
    seq_loader_pkg::parse_state_t                pstate;
    logic [3:0]                                  digits_left;
    logic [31:0]                                 byte_total;
    logic [31:0]                                 byte_seen;
    logic [2:0]                                  byte_pos;
    logic [seq_loader_pkg::ENTRY_W-1:0]          entry;
    logic [seq_loader_pkg::INDEX_W-1:0]          wr_index;
    logic [15:0]                                 entry_count;
    logic [seq_loader_pkg::CHAN_W-1:0]           load_chan;
    logic                                        done;
    logic                                        def_err;
    logic                                        range_err;
    logic [15:0]                                 def_last;
    logic                                        seq_on;
    logic                                        jump_src;
    logic [seq_loader_pkg::CHAN_W-1:0]           chan;
    logic [31:0]                                 step_value;
    logic [31:0]                                 segment_value;
    logic [31:0]                                 loops_value;
    logic [31:0]                                 jump_value;
    logic [seq_loader_pkg::CHANNELS-1:0][15:0]   length;
    logic                                        ev_prev;
    logic                                        pend_write;
    logic                                        pend_read;
    logic [7:0]                                  pend_addr;
    logic                                        hreadyout;
    logic                                        hresp;
    logic [31:0]                                 hrdata;
    logic                                        mem_we;
    logic [seq_loader_pkg::ADDR_W-1:0]           mem_waddr;
    logic [seq_loader_pkg::ENTRY_W-1:0]          mem_wdata;
    logic                                        mem_re;
    logic [seq_loader_pkg::ADDR_W-1:0]           mem_raddr;
    seq_loader_pkg::play_state_t                 qstate;
    logic [seq_loader_pkg::INDEX_W-1:0]          play_index;
    logic [31:0]                                 loops_left;
    logic                                        cur_jump;
    logic [15:0]                                 play_segment;
    logic [15:0]                                 play_step;
    logic                                        play_valid;
    logic                                        dwell;
    logic                                        restart;
  } loader_state_t;

  localparam loader_state_t STATE_RESET = '{
    pstate    : seq_loader_pkg::P_HUNT,
    qstate    : seq_loader_pkg::Q_IDLE,
    hreadyout : 1'b1,
    default   : '0
  };

  loader_state_t                      state;
  loader_state_t                      next_state;
  logic [seq_loader_pkg::ENTRY_W-1:0] mem_rdata;

  // ==========================================================
  // Table storage, one region per channel
  table_memory table_memory_i
  (
    .clk   (clk),
    .we    (state.mem_we),
    .waddr (state.mem_waddr),
    .wdata (state.mem_wdata),
    .re    (state.mem_re),
    .raddr (state.mem_raddr),
    .rdata (mem_rdata)
  );

  // ==========================================================
  // Next state
  always_comb
  begin : next_logic
    logic                               accept;
    logic                               wr_strobe;
    logic                               define_req;
    logic                               trigger_req;
    logic                               range_ok;
    logic                               order_ok;
    logic                               restart_req;
    logic                               release_req;
    logic                               wrap;
    logic [15:0]                        restart_len;
    logic [31:0]                        step_less;
    logic [31:0]                        scaled;
    logic [7:0]                         digit_byte;
    logic [3:0]                         digit;
    logic                               is_digit;
    logic [seq_loader_pkg::ENTRY_W-1:0] assembled;
    logic [15:0]                        count_now;
    logic [15:0]                        next_index;
    logic [31:0]                        rd_word;
    accept      = hsel && htrans[1] && hready;
    wr_strobe   = state.pend_write;
    define_req  = 1'b0;
    trigger_req = 1'b0;
    restart_req = 1'b0;
    restart_len = state.length[state.chan];
    step_less   = state.step_value - 32'h1;
    digit_byte  = rx_data - seq_loader_pkg::DIGIT_ZERO;
    digit       = digit_byte[3:0];
    is_digit    = (rx_data >= seq_loader_pkg::DIGIT_ZERO) && (rx_data <= seq_loader_pkg::DIGIT_NINE);
    scaled      = {state.byte_total[28:0], 3'h0} + {state.byte_total[30:0], 1'h0} + {28'h0, digit};
    assembled   = state.entry;
    count_now   = state.entry_count;
    next_index  = {1'b0, state.play_index} + 16'h1;
    wrap        = next_index >= state.length[state.chan];
    release_req = 1'b0;
    rd_word     = 32'h0;
    range_ok    = (state.step_value >= 32'h1)
                  && (state.step_value <= {16'h0, seq_loader_pkg::MAX_STEPS})
                  && (state.segment_value >= {16'h0, seq_loader_pkg::MIN_SEGMENT})
                  && (state.segment_value <= {16'h0, seq_loader_pkg::MAX_SEGMENT})
                  && (state.loops_value >= seq_loader_pkg::MIN_LOOPS)
                  && (state.loops_value <= seq_loader_pkg::MAX_LOOPS)
                  && (state.jump_value <= {16'h0, seq_loader_pkg::MAX_JUMP});
    order_ok    = (state.step_value == 32'h1) || (state.step_value == {16'h0, state.def_last} + 32'h1);

    next_state         = state;
    next_state.mem_we  = 1'b0;
    next_state.mem_re  = 1'b0;
    next_state.restart = 1'b0;
    next_state.ev_prev = event_in;
    next_state.hresp   = 1'b0;

    // ========================================================
    // Register bus: writes complete with no wait, reads take one
    case (state.pend_addr)
      seq_loader_pkg::REG_CTRL:
      begin
        rd_word[seq_loader_pkg::CTRL_SEQ]  = state.seq_on;
        rd_word[seq_loader_pkg::CTRL_JSRC] = state.jump_src;
        rd_word[seq_loader_pkg::CTRL_CHAN] = state.chan;
      end
      seq_loader_pkg::REG_STEP:    rd_word = state.step_value;
      seq_loader_pkg::REG_SEGMENT: rd_word = state.segment_value;
      seq_loader_pkg::REG_LOOPS:   rd_word = state.loops_value;
      seq_loader_pkg::REG_JUMP:    rd_word = state.jump_value;
      seq_loader_pkg::REG_STATUS:
      begin
        rd_word[seq_loader_pkg::ST_DEF_ERR] = state.def_err;
        rd_word[seq_loader_pkg::ST_DONE]    = state.done;
        rd_word[seq_loader_pkg::ST_RANGE]   = state.range_err;
        rd_word[seq_loader_pkg::ST_BUSY]    = state.pstate != seq_loader_pkg::P_HUNT;
      end
      seq_loader_pkg::REG_LENGTH:  rd_word = {16'h0, state.length[state.chan]};
      seq_loader_pkg::REG_PLAY:    rd_word = {state.play_segment, state.play_step};
      default:                     rd_word = 32'h0;
    endcase

    if (state.pend_read)
    begin
      next_state.pend_read = 1'b0;
      next_state.hrdata    = rd_word;
      next_state.hreadyout = 1'b1;
    end

    if (wr_strobe)
    begin
      next_state.pend_write = 1'b0;
      case (state.pend_addr)
        seq_loader_pkg::REG_CTRL:
        begin
          next_state.seq_on   = hwdata[seq_loader_pkg::CTRL_SEQ];
          next_state.jump_src = hwdata[seq_loader_pkg::CTRL_JSRC];
          next_state.chan     = hwdata[seq_loader_pkg::CTRL_CHAN];
        end
        seq_loader_pkg::REG_STEP:    next_state.step_value    = hwdata;
        seq_loader_pkg::REG_SEGMENT: next_state.segment_value = hwdata;
        seq_loader_pkg::REG_LOOPS:   next_state.loops_value   = hwdata;
        seq_loader_pkg::REG_JUMP:    next_state.jump_value    = hwdata;
        seq_loader_pkg::REG_COMMAND:
        begin
          define_req  = hwdata[seq_loader_pkg::CMD_DEFINE];
          trigger_req = hwdata[seq_loader_pkg::CMD_TRIGGER];
        end
        seq_loader_pkg::REG_LENGTH:
        begin
          // A preset length only holds until the next step definition or block load on this channel
          if ((hwdata >= {16'h0, seq_loader_pkg::MIN_STEPS}) && (hwdata <= {16'h0, seq_loader_pkg::MAX_STEPS}))
          begin
            next_state.length[state.chan] = hwdata[15:0];
          end
          else
          begin
            next_state.range_err = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    if (accept)
    begin
      next_state.pend_addr  = haddr[7:0];
      next_state.pend_write = hwrite;
      next_state.pend_read  = !hwrite;
      next_state.hreadyout  = hwrite;
    end

    // ========================================================
    // Single step definition
    if (define_req)
    begin
      // Refused while a binary block owns the table write port
      if (state.pstate != seq_loader_pkg::P_HUNT)
      begin
        next_state.def_err = 1'b1;
      end
      else if (!range_ok)
      begin
        next_state.range_err = 1'b1;
      end
      else if (!order_ok)
      begin
        next_state.def_err = 1'b1;
      end
      else
      begin
        next_state.mem_we    = 1'b1;
        next_state.mem_waddr = {state.chan, step_less[seq_loader_pkg::INDEX_W-1:0]};
        next_state.mem_wdata = {state.jump_value[15:0], state.segment_value[15:0], state.loops_value};
        next_state.def_last  = state.step_value[15:0];
        next_state.length[state.chan] = state.step_value[15:0];
        next_state.def_err   = 1'b0;
        next_state.range_err = 1'b0;
        restart_len          = state.step_value[15:0];
        restart_req          = state.seq_on;
      end
    end

    // ========================================================
    // Binary block parser
    if (rx_valid)
    begin
      unique case (state.pstate)
        seq_loader_pkg::P_HUNT:
        begin
          if (rx_data == seq_loader_pkg::HASH_CHAR)
          begin
            next_state.pstate = seq_loader_pkg::P_NDIG;
            next_state.done   = 1'b0;
          end
        end
        seq_loader_pkg::P_NDIG:
        begin
          // A zero digit count would be an indefinite block, which is not supported
          if ((rx_data >= seq_loader_pkg::DIGIT_ONE) && (rx_data <= seq_loader_pkg::DIGIT_NINE))
          begin
            next_state.digits_left = digit;
            next_state.byte_total  = 32'h0;
            next_state.pstate      = seq_loader_pkg::P_COUNT;
          end
          else
          begin
            next_state.pstate = seq_loader_pkg::P_HUNT;
          end
        end
        seq_loader_pkg::P_COUNT:
        begin
          if (!is_digit)
          begin
            next_state.pstate = seq_loader_pkg::P_HUNT;
          end
          else
          begin
            next_state.byte_total  = scaled;
            next_state.digits_left = state.digits_left - 4'h1;
            if (state.digits_left == 4'h1)
            begin
              next_state.byte_seen   = 32'h0;
              next_state.byte_pos    = 3'h0;
              next_state.wr_index    = '0;
              next_state.entry_count = 16'h0;
              next_state.entry       = '0;
              next_state.load_chan   = state.chan;
              if (scaled == 32'h0)
              begin
                next_state.pstate = seq_loader_pkg::P_HUNT;
                next_state.done   = 1'b1;
              end
              else
              begin
                next_state.pstate = seq_loader_pkg::P_DATA;
              end
            end
          end
        end
        seq_loader_pkg::P_DATA:
        begin
          // Every byte value is payload here, CR and LF included
          assembled[{state.byte_pos, 3'h0} +: 8] = rx_data;
          next_state.entry     = assembled;
          next_state.byte_pos  = state.byte_pos + 3'h1;
          next_state.byte_seen = state.byte_seen + 32'h1;
          if (state.byte_pos == seq_loader_pkg::LAST_BYTE)
          begin
            next_state.mem_we    = 1'b1;
            next_state.mem_waddr = {state.load_chan, state.wr_index};
            next_state.mem_wdata = assembled;
            next_state.wr_index  = state.wr_index + 15'h1;
            count_now            = state.entry_count + 16'h1;
            next_state.entry_count = count_now;
          end
          if ((state.byte_seen + 32'h1 == state.byte_total) || rx_eoi)
          begin
            next_state.pstate = seq_loader_pkg::P_HUNT;
            next_state.done   = 1'b1;
            next_state.length[state.load_chan] = count_now;
          end
        end
        default:
        begin
          next_state.pstate = seq_loader_pkg::P_HUNT;
        end
      endcase
    end

    // ========================================================
    // Step player
    release_req = state.jump_src ? (event_in && !state.ev_prev) : trigger_req;
    if (restart_req)
    begin
      next_state.restart    = 1'b1;
      next_state.dwell      = 1'b0;
      next_state.play_valid = 1'b0;
      next_state.play_index = '0;
      if (restart_len >= seq_loader_pkg::MIN_STEPS)
      begin
        next_state.mem_re    = 1'b1;
        next_state.mem_raddr = {state.chan, {seq_loader_pkg::INDEX_W{1'b0}}};
        next_state.qstate    = seq_loader_pkg::Q_FETCH;
      end
      else
      begin
        next_state.qstate = seq_loader_pkg::Q_IDLE;
      end
    end
    else if (!state.seq_on)
    begin
      next_state.qstate     = seq_loader_pkg::Q_IDLE;
      next_state.play_valid = 1'b0;
      next_state.dwell      = 1'b0;
    end
    else
    begin
      unique case (state.qstate)
        seq_loader_pkg::Q_IDLE:
        begin
          if (state.length[state.chan] >= seq_loader_pkg::MIN_STEPS)
          begin
            next_state.mem_re     = 1'b1;
            next_state.mem_raddr  = {state.chan, {seq_loader_pkg::INDEX_W{1'b0}}};
            next_state.play_index = '0;
            next_state.qstate     = seq_loader_pkg::Q_FETCH;
          end
        end
        seq_loader_pkg::Q_FETCH:
        begin
          next_state.qstate = seq_loader_pkg::Q_LOAD;
        end
        seq_loader_pkg::Q_LOAD:
        begin
          next_state.play_segment = mem_rdata[seq_loader_pkg::SEG_LSB +: 16];
          next_state.loops_left   = mem_rdata[seq_loader_pkg::LOOPS_LSB +: 32];
          next_state.cur_jump     = |mem_rdata[seq_loader_pkg::JUMP_LSB +: 16];
          next_state.play_step    = {1'b0, state.play_index} + 16'h1;
          next_state.play_valid   = 1'b1;
          next_state.qstate       = seq_loader_pkg::Q_PLAY;
        end
        seq_loader_pkg::Q_PLAY:
        begin
          if (segment_done)
          begin
            if (state.loops_left > seq_loader_pkg::MIN_LOOPS)
            begin
              next_state.loops_left = state.loops_left - 32'h1;
            end
            else if (state.cur_jump)
            begin
              next_state.dwell  = 1'b1;
              next_state.qstate = seq_loader_pkg::Q_DWELL;
            end
            else
            begin
              next_state.play_index = wrap ? '0 : next_index[seq_loader_pkg::INDEX_W-1:0];
              next_state.mem_re     = 1'b1;
              next_state.mem_raddr  = {state.chan, wrap ? {seq_loader_pkg::INDEX_W{1'b0}}
                                                        : next_index[seq_loader_pkg::INDEX_W-1:0]};
              next_state.qstate     = seq_loader_pkg::Q_FETCH;
            end
          end
        end
        seq_loader_pkg::Q_DWELL:
        begin
          if (release_req)
          begin
            next_state.dwell      = 1'b0;
            next_state.play_index = wrap ? '0 : next_index[seq_loader_pkg::INDEX_W-1:0];
            next_state.mem_re     = 1'b1;
            next_state.mem_raddr  = {state.chan, wrap ? {seq_loader_pkg::INDEX_W{1'b0}}
                                                      : next_index[seq_loader_pkg::INDEX_W-1:0]};
            next_state.qstate     = seq_loader_pkg::Q_FETCH;
          end
        end
        default:
        begin
          next_state.qstate = seq_loader_pkg::Q_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign hreadyout    = state.hreadyout;
  assign hrdata       = state.hrdata;
  assign hresp        = state.hresp;
  assign play_segment = state.play_segment;
  assign play_step    = state.play_step;
  assign play_valid   = state.play_valid;
  assign dwell        = state.dwell;
  assign restart      = state.restart;
endmodule : sequence_table_loader

// *** table_memory.sv ***
// Purpose: Step table storage for all channels
// Assumes: One write and one read port on the same clock
// Notes:   Read data is registered, one cycle after re
`timescale 1ns/100ps
module table_memory
(
  input  wire logic                                clk,
  input  wire logic                                we,
  input  wire logic [seq_loader_pkg::ADDR_W-1:0]   waddr,
  input  wire logic [seq_loader_pkg::ENTRY_W-1:0]  wdata,
  input  wire logic                                re,
  input  wire logic [seq_loader_pkg::ADDR_W-1:0]   raddr,
  output logic      [seq_loader_pkg::ENTRY_W-1:0]  rdata
);
  logic [seq_loader_pkg::ENTRY_W-1:0] mem [0:(1 << seq_loader_pkg::ADDR_W)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : table_memory

// *** tb_top.sv ***
// Purpose: Self-checking loader bench
// Assumes: hready fed back from hreadyout
// Notes:   segment_done held high so steps pass fast
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; $display("FAIL %s %h %h", n, e, s); end end
module tb_top;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, event_in = 0, segment_done = 1, seen = 0;
  logic hresp, hreadyout, play_valid, dwell, restart, rx_valid, rx_eoi;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, hdr = "#224";
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  rx_data;
  logic [15:0] play_segment, play_step;
  logic [63:0] ent [3] = '{64'h1_000f_fd0a, 64'h2_0000_0d0a, 64'h3_0000_0001};
  wire         hready = hreadyout;
  int          n_mismatch = 0, checks_done = 0, k, i;
  always #20 clk = ~clk;
  always @(posedge clk) if (restart === 1'b1) seen <= 1'b1;
  sequence_table_loader sequence_table_loader_i
  (
    .clk          (clk),
    .reset        (reset),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hrdata       (hrdata),
    .hresp        (hresp),
    .rx_data      (rx_data),
    .rx_valid     (rx_valid),
    .rx_eoi       (rx_eoi),
    .event_in     (event_in),
    .segment_done (segment_done),
    .play_segment (play_segment),
    .play_step    (play_step),
    .play_valid   (play_valid),
    .dwell        (dwell),
    .restart      (restart)
  );
  host_model host_model_i
  (
    .clk      (clk),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_eoi   (rx_eoi)
  );
  task test_done;
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task wt(input int w);
    for (k = 0; k < 900 && !(w == 0 ? hreadyout : w == 1 ? dwell : w == 2 ? !dwell : seen); k++) @(posedge clk);
    `CHK("wait", 1'b1, k < 900)
    if (k == 900) test_done();
  endtask : wt
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk) wt(0);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk) wt(0);
    q = hrdata;
  endtask : bus
  task def(input logic [31:0] s, input logic [31:0] g, input logic [31:0] j);
    bus(1, seq_loader_pkg::REG_STEP, s);
    bus(1, seq_loader_pkg::REG_SEGMENT, g);
    bus(1, seq_loader_pkg::REG_LOOPS, 32'h1);
    bus(1, seq_loader_pkg::REG_JUMP, j);
    bus(1, seq_loader_pkg::REG_COMMAND, 32'h1);
  endtask : def
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    bus(1, seq_loader_pkg::REG_CTRL, 32'h0);
    for (i = 3; i >= 0; i--) host_model_i.send(hdr[8*i+:8], 1'b0);
    for (i = 0; i < 24; i++) host_model_i.send(ent[i/8][8*(i%8)+:8], i == 23);
    bus(0, seq_loader_pkg::REG_LENGTH, 0);
    `CHK("len", 32'h3, q)
    bus(0, seq_loader_pkg::REG_STATUS, 0);
    `CHK("done", 1'b1, q[seq_loader_pkg::ST_DONE])
    for (i = 1; i < 5; i++) def(i, i, i == 2);
    bus(0, seq_loader_pkg::REG_LENGTH, 0);
    `CHK("deflen", 32'h4, q)
    def(5, 0, 0);
    bus(0, seq_loader_pkg::REG_STATUS, 0);
    `CHK("range", 1'b1, q[seq_loader_pkg::ST_RANGE])
    bus(1, seq_loader_pkg::REG_CTRL, 32'h3);
    wt(1);
    `CHK("dwseg", 16'h2, play_segment)
    event_in <= 1'b1;
    wt(2);
    event_in <= 1'b0;
    def(1, 1, 0);
    wt(3);
    test_done();
  end
endmodule : tb_top
